//--- pkg/bmi_pkg.sv
// Constants and carrier types for the battery monitor serial target port.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package bmi_pkg;
  // Target address upper six bits; bit 1 comes from the select pin
  localparam logic [5:0] BMI_ADDR_BASE = 6'h14;
  // Highest register address reaching the non-volatile array
  localparam logic [7:0] BMI_NV_TOP = 8'h57;
  // Page size as a mask of the in-page offset bits
  localparam logic [7:0] BMI_PAGE_MASK = 8'h03;
  // Reset value of the internal register address
  localparam logic [7:0] BMI_ADDR_RST = 8'h00;
  // Internal write cycle length (array write time)
  localparam int BMI_WR_MS = 30;
  localparam int BMI_CLK_KHZ = 100000;
  localparam int BMI_WR_CYC = BMI_WR_MS * BMI_CLK_KHZ;
  // Power-up settle time before starts are honoured
  localparam int BMI_PUP_US = 10;
  localparam int BMI_PUP_CYC = BMI_PUP_US * (BMI_CLK_KHZ / 1000);

  // Serial state machine states
  typedef enum logic [2:0] {
    BMI_IDLE = 3'b000,
    BMI_RX = 3'b001,
    BMI_RX_ACK = 3'b010,
    BMI_TX = 3'b011,
    BMI_TX_ACK = 3'b100
  } bmi_state_t;

  // Register access request towards the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic nv;
    logic [7:0] addr;
    logic [7:0] data;
  } bmi_req_t;
endpackage : bmi_pkg

//--- rtl/bmi_i2c_target.sv
// Serial two-wire target port of the battery monitor.
// Assumes host drives the clock, open-drain data joined outside by the
// testbench, and a register file answering reads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module bmi_i2c_target #(
  parameter int WR_CYC = bmi_pkg::BMI_WR_CYC,  // Internal write cycle
  parameter int PUP_CYC = bmi_pkg::BMI_PUP_CYC // Power-up hold-off
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_power_down,                 // Power-down state
  input wire logic i_addr_sel,                   // Address-select strap
  input wire logic i_nonvolatile_access_select,  // Array routing bit
  input wire logic i_protect,                    // Protected-block flag
  input wire logic i_scl,                        // Serial clock pin
  input wire logic i_serial_data_in_line,        // Data input pin
  input wire logic [7:0] i_rd_data,              // Register read data
  output logic o_serial_data_out_line,           // Data output level
  output logic o_serial_data_oe,                 // High while driving low
  output bmi_pkg::bmi_req_t o_req,               // One-cycle access pulse
  output logic o_busy                            // Internal write cycle
);
  import bmi_pkg::*;

  localparam int CW = $clog2(WR_CYC + 1);

  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;

  // Both lines pass two flops before use
  bmi_sync u_scl (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_scl),
    .o_lvl(scl_lvl),
    .o_rise(scl_rise),
    .o_fall(scl_fall)
  );
  bmi_sync u_sda (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_serial_data_in_line),
    .o_lvl(sda_lvl),
    .o_rise(sda_rise),
    .o_fall(sda_fall)
  );

  // Start and stop seen only with clock high
  logic start_ev, stop_ev;
  assign start_ev = sda_fall & scl_lvl;
  assign stop_ev = sda_rise & scl_lvl;

  bmi_state_t st_r, st_nxt;          // Serial state
  logic [2:0] bit_r, bit_nxt;        // Bit index within byte
  logic [7:0] sh_r, sh_nxt;          // Shift register
  logic [1:0] byte_r, byte_nxt;      // 0 addr, 1 reg addr, 2+ data
  logic rd_r, rd_nxt;                // Read direction
  logic ack_r, ack_nxt;              // Acknowledge to drive
  logic wrote_r, wrote_nxt;          // Data byte written this frame
  logic [7:0] ra_r, ra_nxt;          // Register address pointer
  logic oe_r, oe_nxt;                // Data output enable
  bmi_req_t req_r, req_nxt;          // Access pulse
  logic [CW-1:0] wcnt_r, wcnt_nxt;   // Write cycle counter
  logic busy_r, busy_nxt;            // Write cycle active
  logic [CW-1:0] pcnt_r, pcnt_nxt;   // Power-up hold-off counter
  logic ready_r, ready_nxt;          // Power-up complete
  logic sel_r, sel_nxt;              // Captured address strap

  logic active;
  logic [7:0] my_addr;
  logic [7:0] ra_inc;

  // Port usable only out of power-up, power-down and write cycle
  assign active = ready_r & ~i_power_down & ~busy_r;
  // Strap picks the address pair
  assign my_addr = {BMI_ADDR_BASE, sel_r, 1'b0};
  // Page roll-over within four bytes on writes
  assign ra_inc = rd_r ? ra_r + 8'h01 :
    ((ra_r & ~BMI_PAGE_MASK) | ((ra_r + 8'h01) & BMI_PAGE_MASK));

  // Next-state logic for the serial machine and its counters
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    byte_nxt = byte_r;
    rd_nxt = rd_r;
    ack_nxt = ack_r;
    wrote_nxt = wrote_r;
    ra_nxt = ra_r;
    oe_nxt = oe_r;
    req_nxt = '0;
    wcnt_nxt = wcnt_r;
    busy_nxt = busy_r;
    pcnt_nxt = pcnt_r;
    ready_nxt = ready_r;
    sel_nxt = sel_r;
    // Power-up hold-off; strap caught while it runs
    if (!ready_r) begin
      sel_nxt = i_addr_sel;
      if (pcnt_r == CW'(PUP_CYC - 1)) begin
        ready_nxt = 1'b1;
      end else begin
        pcnt_nxt = pcnt_r + 1'b1;
      end
    end
    // Internal write cycle counts down, inputs ignored
    if (busy_r) begin
      if (wcnt_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        wcnt_nxt = wcnt_r - 1'b1;
      end
    end
    if (!active) begin
      // Pin released, machine idle
      st_nxt = BMI_IDLE;
      oe_nxt = 1'b0;
    end else if (start_ev) begin
      // Start or repeated start opens address byte
      st_nxt = BMI_RX;
      bit_nxt = 3'd7;
      byte_nxt = 2'd0;
      oe_nxt = 1'b0;
      wrote_nxt = 1'b0;
    end else if (stop_ev) begin
      // Stop ends any transfer
      st_nxt = BMI_IDLE;
      oe_nxt = 1'b0;
      // Frame closed: a later bare stop must not restart the cycle
      wrote_nxt = 1'b0;
      if (wrote_r) begin
        // Write cycle begins at stop
        busy_nxt = 1'b1;
        wcnt_nxt = CW'(WR_CYC - 1);
      end
    end else begin
      unique case (st_r)
        BMI_IDLE: begin
          oe_nxt = 1'b0;
        end
        BMI_RX: begin
          if (scl_rise) begin
            // Shift in MSB first
            sh_nxt = {sh_r[6:0], sda_lvl};
            bit_nxt = bit_r - 3'd1;
          end
          if (scl_fall) begin
            // Host owns the line while it sends a byte, keep released
            // so a stray drive cannot corrupt its bits
            oe_nxt = 1'b0;
          end
          if (scl_rise && bit_r == 3'd0) begin
            st_nxt = BMI_RX_ACK;
            ack_nxt = 1'b1;
            if (byte_r == 2'd0) begin
              // Match address, last bit is direction
              ack_nxt = ({sh_r[6:0], 1'b0} == my_addr);
              rd_nxt = sda_lvl;
            end else if (byte_r == 2'd1) begin
              // Any start address accepted
              ra_nxt = {sh_r[6:0], sda_lvl};
            end else begin
              // Protected writes not acknowledged
              ack_nxt = ~i_protect;
              if (!i_protect) begin
                req_nxt.wr = 1'b1;
                req_nxt.addr = ra_r;
                req_nxt.data = {sh_r[6:0], sda_lvl};
                req_nxt.nv = i_nonvolatile_access_select &&
                  ra_r <= BMI_NV_TOP;
                wrote_nxt = 1'b1;
                ra_nxt = ra_inc;
              end
            end
          end
        end
        BMI_RX_ACK: begin
          if (scl_fall) begin
            if (oe_r) begin
              // Ninth clock done, release line
              oe_nxt = 1'b0;
              if (byte_r == 2'd0 && rd_r) begin
                // Load first read byte
                st_nxt = BMI_TX;
                sh_nxt = i_rd_data;
                bit_nxt = 3'd7;
                oe_nxt = ~i_rd_data[7];
                req_nxt.rd = 1'b1;
                req_nxt.addr = ra_r;
                req_nxt.nv = i_nonvolatile_access_select &&
                  ra_r <= BMI_NV_TOP;
              end else begin
                // Address, register address, then data bytes
                st_nxt = BMI_RX;
                bit_nxt = 3'd7;
                if (byte_r != 2'd3) begin
                  byte_nxt = byte_r + 2'd1;
                end
              end
            end else if (ack_r) begin
              // Drive ack low while clock is low
              oe_nxt = 1'b1;
            end else begin
              // No ack: drop out until next start
              st_nxt = BMI_IDLE;
            end
          end
        end
        BMI_TX: begin
          if (scl_fall) begin
            if (bit_r == 3'd0) begin
              // Release line for host acknowledge
              st_nxt = BMI_TX_ACK;
              oe_nxt = 1'b0;
            end else begin
              // Next bit, MSB first, changed with clock low
              bit_nxt = bit_r - 3'd1;
              oe_nxt = ~sh_r[bit_r - 3'd1];
            end
          end
        end
        BMI_TX_ACK: begin
          if (scl_rise) begin
            if (sda_lvl) begin
              // Host nack ends transmission
              st_nxt = BMI_IDLE;
            end else begin
              // Host ack advances address
              ra_nxt = ra_r + 8'h01;
              rd_nxt = 1'b1;
            end
          end
          if (scl_fall) begin
            st_nxt = BMI_TX;
            sh_nxt = i_rd_data;
            bit_nxt = 3'd7;
            oe_nxt = ~i_rd_data[7];
            req_nxt.rd = 1'b1;
            req_nxt.addr = ra_r;
            req_nxt.nv = i_nonvolatile_access_select &&
              ra_r <= BMI_NV_TOP;
          end
        end
        default: begin
          st_nxt = BMI_IDLE;
        end
      endcase
    end
  end

  // Register all state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= BMI_IDLE;
      bit_r <= 3'd7;
      sh_r <= 8'h00;
      byte_r <= 2'd0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      wrote_r <= 1'b0;
      ra_r <= BMI_ADDR_RST;
      oe_r <= 1'b0;
      req_r <= '0;
      wcnt_r <= '0;
      busy_r <= 1'b0;
      pcnt_r <= '0;
      ready_r <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      byte_r <= byte_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
      wrote_r <= wrote_nxt;
      ra_r <= ra_nxt;
      oe_r <= oe_nxt;
      req_r <= req_nxt;
      wcnt_r <= wcnt_nxt;
      busy_r <= busy_nxt;
      pcnt_r <= pcnt_nxt;
      ready_r <= ready_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Output drives only low, enable marks drive
  assign o_serial_data_out_line = 1'b0;
  assign o_serial_data_oe = oe_r;
  assign o_req = req_r;
  assign o_busy = busy_r;
endmodule // bmi_i2c_target
`default_nettype wire

//--- rtl/bmi_sync.sv
// Two-flop synchroniser with unfiltered edge detect outputs for one bus line.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module bmi_sync (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_lvl,
  output logic o_rise,
  output logic o_fall
);
  logic s1_r;   // First stage, read only by second
  logic s2_r;   // Second stage
  logic s3_r;   // Previous synced level
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;

  // Next-state for the synchroniser chain
  always_comb begin
    s1_nxt = i_pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // Registers; idle bus reads high
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign o_lvl = s3_r;
  assign o_rise = s2_r & ~s3_r;
  assign o_fall = ~s2_r & s3_r;
endmodule // bmi_sync
`default_nettype wire

//--- testbench/battery_monitor_i2c_target_tb.sv
// Self-checking bench for the serial target port.
// Assumes bmi_host as master and the open-drain wire joined here.
`timescale 1ns/1ps
`default_nettype none
module battery_monitor_i2c_target_tb;
  import bmi_pkg::*;
  localparam int WR = 4000; // Shortened write cycle
  logic clk, rst, pdn, asel, nvsel, prot, oe, dout, busy, h_scl, h_sda;
  logic [7:0] rdat;
  bmi_req_t req;
  bmi_req_t seen[$]; // Access pulses since last clear
  int error_cnt, samples_checked, cyc;
  wire logic sda = h_sda & ~oe; // Pulled-up joined data line
  bmi_i2c_target #(.WR_CYC(WR), .PUP_CYC(4)) dut (.i_clk(clk),
    .i_sys_rst(rst), .i_power_down(pdn), .i_addr_sel(asel),
    .i_nonvolatile_access_select(nvsel), .i_protect(prot), .i_scl(h_scl),
    .i_serial_data_in_line(sda), .i_rd_data(rdat),
    .o_serial_data_out_line(dout), .o_serial_data_oe(oe), .o_req(req),
    .o_busy(busy));
  bmi_host h (.i_clk(clk), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record pulses; cut a hang short
  always @(posedge clk) begin
    if (req.wr || req.rd) seen.push_back(req);
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic check(input string n, input logic [18:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] dev(logic s, logic r);
    return {BMI_ADDR_BASE, s, r};
  endfunction
  function automatic logic [7:0] pat(logic [7:0] a);
    return a ^ 8'hA5;
  endfunction
  // Expected write pulse: address rolls inside its page
  function automatic logic [18:0] ewr(logic [7:0] a, int i, logic [7:0] d);
    logic [7:0] x;
    x = (a & ~BMI_PAGE_MASK) | ((a + 8'(i)) & BMI_PAGE_MASK);
    return {2'b10, nvsel && x <= BMI_NV_TOP, x, d};
  endfunction
  task automatic do_reset(input logic s);
    rst <= 1'b1;
    asel <= s;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    check("oe", oe, 0);
    check("busy", busy, 0);
  endtask
  // Address byte that must go unanswered
  task automatic nack(input logic [7:0] b);
    logic k;
    h.start();
    h.put(b, k);
    check("nack", k, 0);
    h.stop();
    repeat (20) @(posedge clk);
  endtask
  // Byte or page write of n bytes; optionally probe the write cycle
  task automatic wr(input logic [7:0] a, d, input int n, input bit pr);
    logic k;
    seen.delete();
    h.start();
    h.put(dev(asel, 0), k);
    check("addr ack", k, 1);
    h.put(a, k);
    check("reg ack", k, 1);
    for (int i = 0; i < n; i++) begin
      h.put(d + 8'(i), k);
      check("data ack", k, !prot);
    end
    h.stop();
    repeat (8) @(posedge clk);
    check("count", 19'(seen.size()), prot ? 0 : n);
    foreach (seen[i]) check("wr", seen[i], ewr(a, i, d + 8'(i)));
    if (!prot) begin
      check("busy", busy, 1);
      if (pr) nack(dev(asel, 0));
      // Next array write only after this one is done
      for (int t = 0; t < WR && busy !== 1'b0; t++) @(posedge clk);
      check("busy end", busy, 0);
    end
  endtask
  // Random read of n bytes after setting the register address
  task automatic rd(input logic [7:0] a, input int n);
    logic k;
    logic [7:0] b;
    seen.delete();
    h.start();
    h.put(dev(asel, 0), k);
    h.put(a, k);
    rdat <= pat(a);
    h.start();
    h.put(dev(asel, 1), k);
    check("rd ack", k, 1);
    for (int i = 0; i < n; i++) begin
      fork
        h.get(i < n - 1, b);
        begin
          repeat (300) @(posedge clk);
          rdat <= pat(a + 8'(i + 1));
        end
      join
      check("rd data", b, pat(a + 8'(i)));
      if (i < seen.size()) check("rd addr", seen[i].addr, a + 8'(i));
    end
    h.stop();
    check("rd count", 19'(seen.size()), n);
  endtask
  initial begin
    {rst, pdn, asel, nvsel, prot} = '0;
    rdat = '0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(76));
    do_reset(1'b0);
    nvsel <= 1'b1;
    wr(8'h57, 8'($urandom), 1, 1);
    nvsel <= 1'b0; // Page writes go to the registers, never the array
    wr(8'h56, 8'($urandom), 4, 0); // Page wraps from offset 2
    prot <= 1'b1;
    wr(8'($urandom), 8'($urandom), 1, 0);
    prot <= 1'b0;
    nvsel <= 1'($urandom);
    rd(8'($urandom), 3);
    nack(dev(1'b1, 0));
    pdn <= 1'b1;
    nack(dev(1'b0, 0));
    pdn <= 1'b0;
    repeat (20) @(posedge clk);
    do_reset(1'b1);
    wr(8'h58, 8'($urandom), 1, 0);
    nack(dev(1'b0, 1));
    conclude();
  end
endmodule // battery_monitor_i2c_target_tb
`default_nettype wire

//--- testbench/bmi_host.sv
// Bus master model driving clock and data for the serial target port.
// Assumes data is read back from the joined open-drain wire.
`timescale 1ns/1ps
`default_nettype none
module bmi_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  localparam int Q = 63; // Quarter bit: 63 cycles, bit of 252 cycles, under 400 kHz
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One bit: data moves only while clock is low
  task automatic bit_io(input logic d, output logic q);
    o_sda <= d;
    tick(Q);
    o_scl <= 1'b1;
    tick(Q);
    q = i_sda;
    tick(Q);
    o_scl <= 1'b0;
    tick(Q);
  endtask
  // Start, also usable as repeated start
  task automatic start();
    o_sda <= 1'b1;
    tick(Q);
    o_scl <= 1'b1;
    tick(Q);
    o_sda <= 1'b0;
    tick(Q);
    o_scl <= 1'b0;
    tick(Q);
  endtask
  // Stop, ending every transfer
  task automatic stop();
    o_sda <= 1'b0;
    tick(Q);
    o_scl <= 1'b1;
    tick(Q);
    o_sda <= 1'b1;
    tick(Q);
  endtask
  // Send a byte high bit first, free the line for the ack
  task automatic put(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(b[i], q);
    bit_io(1'b1, q);
    ack = ~q;
  endtask
  // Take a byte high bit first, then ack or nack it
  task automatic get(input logic ack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, q);
      b[i] = q;
    end
    bit_io(~ack, q);
  endtask
endmodule // bmi_host
`default_nettype wire

//--- testbench/bmi_i2c_target_chk.sv
// Checker for the serial target port, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module bmi_i2c_target_chk #(
  parameter int WR_CYC = 50,
  parameter int PUP_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_power_down,
  input wire logic i_addr_sel,
  input wire logic i_nonvolatile_access_select,
  input wire logic i_protect,
  input wire logic i_scl,
  input wire logic i_serial_data_in_line,
  input wire logic [7:0] i_rd_data,
  input wire logic o_serial_data_out_line,
  input wire logic o_serial_data_oe,
  input wire bmi_pkg::bmi_req_t o_req,
  input wire logic o_busy
);
  import bmi_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  int busy_n_r; // Cycles spent in the write cycle so far
  int busy_n_nxt;
  // Next count: grows while busy, clears otherwise
  always_comb busy_n_nxt = o_busy ? busy_n_r + 1 : 0;
  // Count register
  always_ff @(posedge i_clk) busy_n_r <= i_sys_rst ? 0 : busy_n_nxt;

  out_line_low_a: assert property (o_serial_data_out_line == 1'b0)
    else $error("data out level not low");
  reset_quiet_a: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_serial_data_oe && !o_busy && o_req == '0)
    else $error("port active after reset");
  pdown_quiet_a: assert property (i_power_down [*3] |-> !o_serial_data_oe)
    else $error("data driven in power-down");
  oe_scl_low_a: assert property ($changed(o_serial_data_oe) |-> !i_scl)
    else $error("data changed while clock high");
  busy_quiet_a: assert property (o_busy |-> !o_serial_data_oe && !o_req.wr)
    else $error("activity during write cycle");
  busy_len_a: assert property ($fell(o_busy) |-> busy_n_r == WR_CYC)
    else $error("write cycle length wrong");
  busy_at_stop_a: assert property ($rose(o_busy) |-> i_scl && i_serial_data_in_line)
    else $error("write cycle began without stop");
  req_pulse_a: assert property (o_req.wr || o_req.rd |=> !o_req.wr && !o_req.rd)
    else $error("access pulse too long");
  nv_route_a: assert property (o_req.wr || o_req.rd |-> o_req.nv ==
    (i_nonvolatile_access_select && o_req.addr <= BMI_NV_TOP))
    else $error("array routing wrong");
  protect_a: assert property (o_req.wr |-> !i_protect)
    else $error("write into protected block");
  cover property (o_req.wr);
  cover property (o_req.rd);
  cover property ($rose(o_busy));
endmodule // bmi_i2c_target_chk
bind bmi_i2c_target bmi_i2c_target_chk #(.WR_CYC(WR_CYC), .PUP_CYC(PUP_CYC))
  chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_power_down(i_power_down),
  .i_addr_sel(i_addr_sel), .i_protect(i_protect), .i_scl(i_scl),
  .i_nonvolatile_access_select(i_nonvolatile_access_select),
  .i_serial_data_in_line(i_serial_data_in_line), .i_rd_data(i_rd_data),
  .o_serial_data_out_line(o_serial_data_out_line), .o_req(o_req),
  .o_serial_data_oe(o_serial_data_oe), .o_busy(o_busy));
`default_nettype wire
